//--- shared/twm_pkg.sv
`default_nettype none
package twm_pkg;
	// ==========================================================
	// Register map and bus widths
	localparam int         ADDR_W      = 4;
	localparam int         DATA_W      = 32;
	localparam logic [3:0] OFS_CTRL    = 4'h0;
	localparam logic [3:0] OFS_STAT    = 4'h4;
	localparam logic [3:0] OFS_DATA    = 4'h8;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ==========================================================
	// Control byte fields
	localparam int CTL_FLAG  = 7;
	localparam int CTL_ACKEN = 6;
	localparam int CTL_STA   = 5;
	localparam int CTL_STO   = 4;
	localparam int CTL_WCOL  = 3;
	localparam int CTL_EN    = 2;
	localparam int CTL_IE    = 0;

	// ==========================================================
	// Status codes, prescaler bits at zero
	localparam logic [7:0] ST_START     = 8'h08;
	localparam logic [7:0] ST_REP       = 8'h10;
	localparam logic [7:0] ST_SLAW_ACK  = 8'h18;
	localparam logic [7:0] ST_SLAW_NACK = 8'h20;
	localparam logic [7:0] ST_DATA_ACK  = 8'h28;
	localparam logic [7:0] ST_DATA_NACK = 8'h30;
	localparam logic [7:0] ST_LOST      = 8'h38;
	localparam logic [7:0] ST_SLAR_ACK  = 8'h40;
	localparam logic [7:0] ST_SLAR_NACK = 8'h48;
	localparam logic [7:0] ST_NONE      = 8'hF8;
	localparam logic [7:0] PRE_MASK     = 8'h03;
	localparam logic [7:0] DATA_RST     = 8'hFF;
	localparam int         DIR_BIT      = 0;
	localparam logic [3:0] ACK_SLOT     = 4'd8;

	// ==========================================================
	// Timing: quarter of a serial bit, least time rounded up
	localparam int CLK_PERIOD_NS  = 100;
	localparam int SCL_QUARTER_NS = 2500;
	localparam int QUARTER_CYC    = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Bit engine commands and controller operations
	typedef enum logic [1:0] {CMD_START = 2'h0, CMD_STOP = 2'h1, CMD_WRITE = 2'h2} twm_cmd_t;
	typedef enum logic [2:0] {
		OP_START = 3'h0, OP_REP = 3'h1, OP_ADDR = 3'h2, OP_DATA = 3'h3, OP_STOP = 3'h4
	} twm_op_t;
endpackage
`default_nettype wire

//--- verilog/twm_bit_engine.sv
`timescale 1ns/1ps
`default_nettype none
module twm_bit_engine #(
	parameter int QUARTER = twm_pkg::QUARTER_CYC
) (
	// Clock and reset
	input  wire logic            aclk,
	input  wire logic            aresetn,
	// Command side
	input  wire logic            en,
	input  wire logic            go,
	input  wire twm_pkg::twm_cmd_t cmd,
	input  wire logic [7:0]      tx_byte,
	output logic                 done,
	output logic                 nack,
	output logic                 lost,
	output logic                 bus_busy,
	// Two-wire pins, enable pulls low
	input  wire logic            scl_i,
	output logic                 scl_oe,
	input  wire logic            sda_i,
	output logic                 sda_oe
);
	import twm_pkg::*;
	localparam int CW = $clog2(QUARTER + 1);
	localparam logic [1:0] PH_HIGH = 2'd2;
	localparam logic [1:0] PH_LAST = 2'd3;
	typedef enum logic [3:0] {
		E_IDLE = 4'b0001, E_START = 4'b0010, E_STOP = 4'b0100, E_BITS = 4'b1000
	} twm_est_t;

	// Sync latency must fit inside one quarter
	if (QUARTER < 4) begin : g_chk
		$error("QUARTER too small");
	end

	twm_est_t st_r, st_nxt;
	logic [1:0] ph_r, ph_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [2:0] scl_s_r, scl_s_nxt, sda_s_r, sda_s_nxt;
	logic scl_f_r, scl_f_nxt, sda_f_r, sda_f_nxt, sda_p_r, sda_p_nxt;
	logic busy_r, busy_nxt, scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
	logic done_r, done_nxt, nack_r, nack_nxt, lost_r, lost_nxt;
	logic tick, adv;

	// Quarter tick; high phase stalls while the slave stretches
	assign tick = (cnt_r == CW'(QUARTER - 1));
	assign adv  = tick && !(ph_r == PH_HIGH && !scl_f_r);

	// ==========================================================
	// Next state: pin filter, bus-free watch, bit sequencing
	always_comb begin
		st_nxt = st_r;
		ph_nxt = ph_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		cnt_nxt = (st_r == E_IDLE || tick) ? '0 : cnt_r + CW'(1);
		scl_s_nxt = {scl_s_r[1:0], scl_i};
		sda_s_nxt = {sda_s_r[1:0], sda_i};
		scl_f_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
		sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
		sda_p_nxt = sda_f_r;
		busy_nxt = busy_r;
		scl_oe_nxt = scl_oe_r;
		sda_oe_nxt = sda_oe_r;
		done_nxt = 1'b0;
		nack_nxt = nack_r;
		lost_nxt = lost_r;
		// Start and stop seen by anyone on the bus
		if (scl_f_r && sda_p_r && !sda_f_r) begin
			busy_nxt = 1'b1;
		end else if (scl_f_r && !sda_p_r && sda_f_r) begin
			busy_nxt = 1'b0;
		end
		if (adv) begin
			ph_nxt = ph_r + 2'd1;
		end
		case (st_r)
			E_IDLE: begin
				if (go) begin
					ph_nxt = '0;
					lost_nxt = 1'b0;
					case (cmd)
						CMD_START: st_nxt = E_START;
						CMD_STOP:  st_nxt = E_STOP;
						default: begin
							st_nxt = E_BITS;
							sh_nxt = tx_byte;
							bit_nxt = '0;
						end
					endcase
				end
			end
			E_START: begin
				if (adv) begin
					case (ph_r)
						2'd0:    sda_oe_nxt = 1'b0;
						2'd1:    scl_oe_nxt = 1'b0;
						PH_HIGH: sda_oe_nxt = 1'b1;
						default: begin
							scl_oe_nxt = 1'b1;
							done_nxt = 1'b1;
							st_nxt = E_IDLE;
						end
					endcase
				end
			end
			E_STOP: begin
				if (adv) begin
					case (ph_r)
						2'd0:    sda_oe_nxt = 1'b1;
						2'd1:    scl_oe_nxt = 1'b0;
						PH_HIGH: sda_oe_nxt = 1'b0;
						default: begin
							done_nxt = 1'b1;
							st_nxt = E_IDLE;
						end
					endcase
				end
			end
			E_BITS: begin
				if (adv) begin
					case (ph_r)
						2'd0:    sda_oe_nxt = (bit_r != ACK_SLOT) && !sh_r[7];
						2'd1:    scl_oe_nxt = 1'b0;
						PH_HIGH: begin
							if (bit_r == ACK_SLOT) begin
								nack_nxt = sda_f_r;
							end else if (!sda_oe_r && !sda_f_r) begin
								// Another master pulled a released one low
								scl_oe_nxt = 1'b0;
								lost_nxt = 1'b1;
								done_nxt = 1'b1;
								st_nxt = E_IDLE;
							end
						end
						default: begin
							scl_oe_nxt = 1'b1;
							sh_nxt = {sh_r[6:0], 1'b0};
							bit_nxt = bit_r + 4'd1;
							if (bit_r == ACK_SLOT) begin
								done_nxt = 1'b1;
								st_nxt = E_IDLE;
							end
						end
					endcase
				end
			end
			default: st_nxt = E_IDLE;
		endcase
		// Disabled unit lets go of both wires at once
		if (!en) begin
			st_nxt = E_IDLE;
			scl_oe_nxt = 1'b0;
			sda_oe_nxt = 1'b0;
			done_nxt = 1'b0;
		end
	end

	// Register stage only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= E_IDLE;
			ph_r <= '0;
			bit_r <= '0;
			sh_r <= '0;
			cnt_r <= '0;
			scl_s_r <= 3'b111;
			sda_s_r <= 3'b111;
			scl_f_r <= 1'b1;
			sda_f_r <= 1'b1;
			sda_p_r <= 1'b1;
			busy_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			done_r <= 1'b0;
			nack_r <= 1'b0;
			lost_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			ph_r <= ph_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			scl_s_r <= scl_s_nxt;
			sda_s_r <= sda_s_nxt;
			scl_f_r <= scl_f_nxt;
			sda_f_r <= sda_f_nxt;
			sda_p_r <= sda_p_nxt;
			busy_r <= busy_nxt;
			scl_oe_r <= scl_oe_nxt;
			sda_oe_r <= sda_oe_nxt;
			done_r <= done_nxt;
			nack_r <= nack_nxt;
			lost_r <= lost_nxt;
		end
	end

	assign done = done_r;
	assign nack = nack_r;
	assign lost = lost_r;
	assign bus_busy = busy_r;
	assign scl_oe = scl_oe_r;
	assign sda_oe = sda_oe_r;
endmodule
`default_nettype wire

//--- verilog/twm_master_tx.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Master work starts only after START; address direction bit picks transmit or receive. Here it only picks the address status codes; bytes are always sent.
// - Control write with flag, start and enable set waits for free bus, sends START.
// - After START goes out, flag sets and status reads 0x08.
// - Writing one to the flag clears it and lets the next bus step run.
// - After address, flag sets with 0x18 ack, 0x20 nack or 0x38 lost.
// - Data write while flag low is dropped and sets write collision.
// - In 0x18 to 0x30 a loaded byte is sent and acknowledge sampled.
// - Clear with start only, after address or data, sends repeated START.
// - Clear with stop only sends STOP, then hardware clears the stop bit.
// - Clear with start and stop sends STOP, then START, stop bit cleared.
// - After lost arbitration, clear releases bus, or with start waits then STARTs.
// - In 0x10 address write bit stays transmitter, read bit switches to receiver. Here both stay transmitter; there is no receive path.
// - After repeated START any slave may be addressed without STOP, bus kept.
// - While the flag is set no further bus activity happens.
// - Direction bit is driven low for write, high for read.
module twm_master_tx #(
	parameter int QUARTER = twm_pkg::QUARTER_CYC
) (
	// Clock and reset
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	// AXI4-Lite write address and data
	input  wire logic [twm_pkg::ADDR_W-1:0]   awaddr,
	input  wire logic                         awvalid,
	output logic                              awready,
	input  wire logic [twm_pkg::DATA_W-1:0]   wdata,
	input  wire logic [twm_pkg::DATA_W/8-1:0] wstrb,
	input  wire logic                         wvalid,
	output logic                              wready,
	// AXI4-Lite write response
	output logic [1:0]                        bresp,
	output logic                              bvalid,
	input  wire logic                         bready,
	// AXI4-Lite read
	input  wire logic [twm_pkg::ADDR_W-1:0]   araddr,
	input  wire logic                         arvalid,
	output logic                              arready,
	output logic [twm_pkg::DATA_W-1:0]        rdata,
	output logic [1:0]                        rresp,
	output logic                              rvalid,
	input  wire logic                         rready,
	// Two-wire pins, open drain
	input  wire logic                         scl_i,
	output logic                              scl_o,
	output logic                              scl_oe,
	input  wire logic                         sda_i,
	output logic                              sda_o,
	output logic                              sda_oe
);
	import twm_pkg::*;
	typedef enum logic [3:0] {
		M_IDLE = 4'b0001, M_WAIT = 4'b0010, M_RUN = 4'b0100, M_HOLD = 4'b1000
	} twm_mst_t;

	// Word match on the upper address bits
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
		reg_hit = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
	endfunction

	// ==========================================================
	// Bus slave state
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [7:0] wbyte_r, wbyte_nxt;
	logic wen_r, wen_nxt, awready_r, awready_nxt, wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic wr_fire, wr_ctl, wr_stat, wr_data, wr_map;

	// Controller state
	twm_mst_t st_r, st_nxt;
	twm_op_t op_r, op_nxt;
	twm_cmd_t cmd_r, cmd_nxt;
	logic flag_r, flag_nxt, acken_r, acken_nxt, sta_r, sta_nxt, sto_r, sto_nxt;
	logic wcol_r, wcol_nxt, en_r, en_nxt, ie_r, ie_nxt, lost_r, lost_nxt;
	logic go_r, go_nxt, lo_r;
	logic [1:0] pre_r, pre_nxt;
	logic [7:0] code_r, code_nxt, data_r, data_nxt, ctl_byte;
	logic eng_done, eng_nack, eng_lost, eng_busy, eng_scl_oe, eng_sda_oe, flag_set;

	// Write fires once both halves are held and no response is pending
	assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
	assign wr_map  = reg_hit(awaddr_r, OFS_CTRL) || reg_hit(awaddr_r, OFS_STAT)
		|| reg_hit(awaddr_r, OFS_DATA);
	assign wr_ctl  = wr_fire && wen_r && reg_hit(awaddr_r, OFS_CTRL);
	assign wr_stat = wr_fire && wen_r && reg_hit(awaddr_r, OFS_STAT);
	assign wr_data = wr_fire && wen_r && reg_hit(awaddr_r, OFS_DATA);
	// Reserved bit always reads zero
	assign ctl_byte = {flag_r, acken_r, sta_r, sto_r, wcol_r, en_r, 1'b0, ie_r};

	// ==========================================================
	// AXI4-Lite slave: address and data in either order
	always_comb begin
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		awaddr_nxt = awaddr_r;
		wbyte_nxt = wbyte_r;
		wen_nxt = wen_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (awvalid && awready_r) begin
			aw_got_nxt = 1'b1;
			awaddr_nxt = awaddr;
		end
		if (wvalid && wready_r) begin
			w_got_nxt = 1'b1;
			wbyte_nxt = wdata[7:0];
			wen_nxt = wstrb[0];
		end
		if (bvalid_r && bready) begin
			bvalid_nxt = 1'b0;
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
		end
		if (wr_fire) begin
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_map ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_r && rready) begin
			rvalid_nxt = 1'b0;
		end
		if (arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = '0;
			if (reg_hit(araddr, OFS_CTRL)) begin
				rdata_nxt[7:0] = ctl_byte;
			end else if (reg_hit(araddr, OFS_STAT)) begin
				rdata_nxt[7:0] = code_r | {6'd0, pre_r};
			end else if (reg_hit(araddr, OFS_DATA)) begin
				rdata_nxt[7:0] = data_r;
			end else begin
				rresp_nxt = RESP_SLVERR;
			end
		end
		awready_nxt = !aw_got_nxt && !bvalid_nxt;
		wready_nxt = !w_got_nxt && !bvalid_nxt;
		arready_nxt = !rvalid_nxt;
	end

	// Bus slave registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= '0;
			wbyte_r <= '0;
			wen_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= '0;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awaddr_r <= awaddr_nxt;
			wbyte_r <= wbyte_nxt;
			wen_r <= wen_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ==========================================================
	// Controller: registers seen by software and the step sequencer
	// flag raised on every finished step but STOP
	assign flag_set = (st_r == M_RUN) && eng_done && (op_r != OP_STOP) && en_r;

	always_comb begin
		st_nxt = st_r;
		op_nxt = op_r;
		cmd_nxt = cmd_r;
		go_nxt = 1'b0;
		flag_nxt = flag_r;
		acken_nxt = acken_r;
		sta_nxt = sta_r;
		sto_nxt = sto_r;
		wcol_nxt = wcol_r;
		en_nxt = en_r;
		ie_nxt = ie_r;
		lost_nxt = lost_r;
		pre_nxt = pre_r;
		code_nxt = code_r;
		data_nxt = data_r;
		// hardware drops stop once STOP is out
		if (st_r == M_RUN && eng_done && op_r == OP_STOP) begin
			sto_nxt = 1'b0;
		end
		// write one clears flag; ack enable only stored
		if (wr_ctl) begin
			acken_nxt = wbyte_r[CTL_ACKEN];
			sta_nxt = wbyte_r[CTL_STA];
			sto_nxt = wbyte_r[CTL_STO];
			en_nxt = wbyte_r[CTL_EN];
			ie_nxt = wbyte_r[CTL_IE];
			if (wbyte_r[CTL_FLAG]) begin
				flag_nxt = 1'b0;
			end
		end
		if (wr_stat) begin
			pre_nxt = wbyte_r[1:0] & PRE_MASK[1:0];
		end
		if (wr_data) begin
			if (flag_r) begin
				data_nxt = wbyte_r;
				wcol_nxt = 1'b0;
			end else begin
				wcol_nxt = 1'b1;
			end
		end
		// Set beats a software clear in the same cycle
		if (flag_set) begin
			flag_nxt = 1'b1;
		end
		case (st_r)
			M_IDLE: begin
				// START request waits for a free bus
				if (en_r && sta_r && !flag_r) begin
					st_nxt = M_WAIT;
				end
			end
			M_WAIT: begin
				if (!eng_busy) begin
					go_nxt = 1'b1;
					cmd_nxt = CMD_START;
					op_nxt = OP_START;
					lost_nxt = 1'b0;
					st_nxt = M_RUN;
				end
			end
			M_RUN: begin
				if (eng_done) begin
					st_nxt = M_HOLD;
					case (op_r)
						OP_START: code_nxt = ST_START;
						OP_REP:   code_nxt = ST_REP;
						OP_ADDR: begin
							if (eng_lost) begin
								code_nxt = ST_LOST;
							end else if (data_r[DIR_BIT]) begin
								code_nxt = eng_nack ? ST_SLAR_NACK : ST_SLAR_ACK;
							end else begin
								code_nxt = eng_nack ? ST_SLAW_NACK : ST_SLAW_ACK;
							end
						end
						OP_DATA: begin
							if (eng_lost) begin
								code_nxt = ST_LOST;
							end else begin
								code_nxt = eng_nack ? ST_DATA_NACK : ST_DATA_ACK;
							end
						end
						default: begin
							code_nxt = ST_NONE;
							st_nxt = M_IDLE;
						end
					endcase
					lost_nxt = eng_lost;
				end
			end
			M_HOLD: begin
				// nothing moves until the flag is cleared
				if (!flag_r) begin
					if (lost_r) begin
						// released already; retry START or fall back
						lost_nxt = 1'b0;
						code_nxt = ST_NONE;
						st_nxt = sta_r ? M_WAIT : M_IDLE;
					end else if (sto_r) begin
						// STOP first; a pending start follows from idle
						go_nxt = 1'b1;
						cmd_nxt = CMD_STOP;
						op_nxt = OP_STOP;
						st_nxt = M_RUN;
					end else if (sta_r) begin
						go_nxt = 1'b1;
						cmd_nxt = CMD_START;
						op_nxt = OP_REP;
						st_nxt = M_RUN;
					end else begin
						// send loaded byte, first one after START is address
						go_nxt = 1'b1;
						cmd_nxt = CMD_WRITE;
						op_nxt = (op_r == OP_START || op_r == OP_REP) ? OP_ADDR : OP_DATA;
						st_nxt = M_RUN;
					end
				end
			end
			default: st_nxt = M_IDLE;
		endcase
		// Disable drops any transfer in flight
		if (!en_r) begin
			st_nxt = M_IDLE;
			go_nxt = 1'b0;
		end
	end

	// Controller registers; pin output levels stay low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= M_IDLE;
			op_r <= OP_STOP;
			cmd_r <= CMD_START;
			go_r <= 1'b0;
			flag_r <= 1'b0;
			acken_r <= 1'b0;
			sta_r <= 1'b0;
			sto_r <= 1'b0;
			wcol_r <= 1'b0;
			en_r <= 1'b0;
			ie_r <= 1'b0;
			lost_r <= 1'b0;
			pre_r <= '0;
			code_r <= ST_NONE;
			data_r <= DATA_RST;
			lo_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			op_r <= op_nxt;
			cmd_r <= cmd_nxt;
			go_r <= go_nxt;
			flag_r <= flag_nxt;
			acken_r <= acken_nxt;
			sta_r <= sta_nxt;
			sto_r <= sto_nxt;
			wcol_r <= wcol_nxt;
			en_r <= en_nxt;
			ie_r <= ie_nxt;
			lost_r <= lost_nxt;
			pre_r <= pre_nxt;
			code_r <= code_nxt;
			data_r <= data_nxt;
			lo_r <= 1'b0;
		end
	end

	// ==========================================================
	// Bit engine
	twm_bit_engine #(.QUARTER(QUARTER)) u_bits (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.en       (en_r),
		.go       (go_r),
		.cmd      (cmd_r),
		.tx_byte  (data_r),
		.done     (eng_done),
		.nack     (eng_nack),
		.lost     (eng_lost),
		.bus_busy (eng_busy),
		.scl_i    (scl_i),
		.scl_oe   (eng_scl_oe),
		.sda_i    (sda_i),
		.sda_oe   (eng_sda_oe)
	);

	// Outputs
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;
	assign scl_o = lo_r;
	assign sda_o = lo_r;
	assign scl_oe = eng_scl_oe;
	assign sda_oe = eng_sda_oe;

	// ==========================================================
	// Checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_START_CODE: assert property (st_r == M_RUN && eng_done && op_r == OP_START && en_r
		|=> flag_r && code_r == ST_START) else $error("start status wrong");
	AST_ADDR_ACK: assert property (st_r == M_RUN && eng_done && op_r == OP_ADDR && en_r
		&& !eng_lost && !eng_nack && !data_r[DIR_BIT] |=> flag_r && code_r == ST_SLAW_ACK)
		else $error("address ack status wrong");
	AST_DATA_NACK: assert property (st_r == M_RUN && eng_done && op_r == OP_DATA && en_r
		&& !eng_lost && eng_nack |=> flag_r && code_r == ST_DATA_NACK)
		else $error("data nack status wrong");
	AST_LOST_CODE: assert property (st_r == M_RUN && eng_done && eng_lost && en_r
		|=> code_r == ST_LOST && lost_r) else $error("lost status wrong");
	AST_WCOL: assert property (wr_data && !flag_r |=> wcol_r && $stable(data_r))
		else $error("collision not flagged");
	AST_FLAG_CLR: assert property (wr_ctl && wbyte_r[CTL_FLAG] && !flag_set |=> !flag_r)
		else $error("flag not cleared");
	AST_HOLD: assert property (flag_r && st_r == M_HOLD |-> !go_r ##1 !go_r)
		else $error("bus step while flag set");
	AST_STOP_CLR: assert property (st_r == M_RUN && eng_done && op_r == OP_STOP && !wr_ctl
		|=> !sto_r) else $error("stop bit not cleared");
	AST_REP_GO: assert property (st_r == M_HOLD && !flag_r && sta_r && !sto_r && !lost_r
		&& en_r |=> go_r && cmd_r == CMD_START && op_r == OP_REP)
		else $error("repeated start not issued");
endmodule
`default_nettype wire

//--- verif/twm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Slave receiver on the two-wire bus
module twm_slave_model (
	// Wire levels
	input  wire logic       scl,
	input  wire logic       sda,
	// Test controls
	input  wire logic       nack,
	input  wire logic       jam,
	// Pin drive and captured byte
	output logic            sda_oe,
	output logic [7:0]      last_byte
);
	int unsigned cnt    = 0;
	logic [7:0]  sh     = 8'h00;
	logic        ack_oe = 1'b0;
	// Jam steals arbitration inside bit cells only
	assign sda_oe = ack_oe | (jam & (cnt < 8));
	// Start seen, frame restarts
	always @(negedge sda) if (scl) cnt <= 0;
	always @(posedge scl) begin
		if (cnt < 8) sh <= {sh[6:0], sda};
		cnt <= cnt + 1;
	end
	always @(negedge scl) begin
		ack_oe <= (cnt == 8) & !nack;
		if (cnt == 9) begin
			cnt       <= 0;
			last_byte <= sh;
		end
	end
endmodule
`default_nettype wire

//--- verif/test_twm_master_tx.sv
`timescale 1ns/1ps
`default_nettype none
module test_twm_master_tx;
	import twm_pkg::*;
	// ==========
	// Bus, pins and counters
	logic              aclk = 0, aresetn = 0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [DATA_W-1:0] wdata = '0, rdata, rd_v;
	logic [3:0]        wstrb = 4'hF;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp, rd_r;
	logic              scl_o, scl_oe, sda_o, sda_oe, s_oe, nack = 0, jam = 0;
	logic [7:0]        got_byte;
	int                err_count = 0, num_checks = 0, cyc = 0;
	// Pull-ups win unless someone pulls low
	wire               scl = !scl_oe;
	wire               sda = !(sda_oe | s_oe);

	always #50 aclk = !aclk;

	twm_master_tx #(.QUARTER(4)) u_dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
	twm_slave_model u_slave (.scl(scl), .sda(sda), .nack(nack), .jam(jam), .sda_oe(s_oe),
		.last_byte(got_byte));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// Ready is looked at mid-cycle, where it equals its value at the next edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic ta, tw;
		awaddr  <= a;
		wdata   <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		@(negedge aclk);
		while (awvalid | wvalid) begin
			ta = awvalid & awready;
			tw = wvalid & wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			@(negedge aclk);
		end
		@(posedge aclk);
		bready <= 1'b1;
		@(negedge aclk);
		while (!bvalid) @(negedge aclk);
		chk({30'h0, bresp}, {30'h0, RESP_OKAY});
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		araddr  <= a;
		arvalid <= 1'b1;
		@(negedge aclk);
		while (!arready) @(negedge aclk);
		@(posedge aclk);
		arvalid <= 1'b0;
		rready  <= 1'b1;
		@(negedge aclk);
		while (!rvalid) @(negedge aclk);
		rd_v = rdata;
		rd_r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// Control write, poll the flag, then compare the status code
	task automatic step(input logic [7:0] c, input logic [7:0] st);
		wr(OFS_CTRL, c);
		rd(OFS_CTRL);
		while (!rd_v[CTL_FLAG]) rd(OFS_CTRL);
		rd(OFS_STAT);
		chk(rd_v & 32'h0000_00F8, {24'h00_0000, st});
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Hang guard, far above the few thousand cycles needed
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			final_report;
		end
	end

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(OFS_CTRL);
		chk(rd_v, 32'h0000_0000);
		rd(OFS_STAT);
		chk(rd_v, 32'h0000_00F8);
		rd(OFS_DATA);
		chk(rd_v, 32'h0000_00FF);
		rd(4'hC);
		chk({30'h0, rd_r}, {30'h0, RESP_SLVERR});
		wr(OFS_STAT, 8'h03);
		rd(OFS_STAT);
		chk(rd_v, 32'h0000_00FB);
		wr(OFS_DATA, 8'h11);
		rd(OFS_CTRL);
		chk(rd_v & 32'h0000_0008, 32'h0000_0008);
		rd(OFS_DATA);
		chk(rd_v, 32'h0000_00FF);
		step(8'hA4, ST_START);
		repeat (100) @(posedge aclk);
		chk({31'h0, scl}, 32'h0000_0000);
		chk({30'h0, scl_o, sda_o}, 32'h0000_0000);
		wr(OFS_DATA, 8'hA0);
		step(8'h84, ST_SLAW_ACK);
		chk({24'h0, got_byte}, 32'h0000_00A0);
		wr(OFS_DATA, 8'h5A);
		step(8'hC4, ST_DATA_ACK);
		chk({24'h0, got_byte}, 32'h0000_005A);
		nack <= 1'b1;
		wr(OFS_DATA, 8'h33);
		step(8'h84, ST_DATA_NACK);
		step(8'hA4, ST_REP);
		wr(OFS_DATA, 8'hE4);
		step(8'h84, ST_SLAW_NACK);
		nack <= 1'b0;
		step(8'hA4, ST_REP);
		wr(OFS_DATA, 8'hE4);
		step(8'h84, ST_SLAW_ACK);
		step(8'hA4, ST_REP);
		wr(OFS_DATA, 8'hE5);
		step(8'h84, ST_SLAR_ACK);
		chk({24'h0, got_byte}, 32'h0000_00E5);
		step(8'hB4, ST_START);
		rd(OFS_CTRL);
		chk(rd_v & 32'h0000_0010, 32'h0000_0000);
		jam <= 1'b1;
		wr(OFS_DATA, 8'hA0);
		step(8'h84, ST_LOST);
		wr(OFS_CTRL, 8'h84);
		jam <= 1'b0;
		repeat (100) @(posedge aclk);
		rd(OFS_STAT);
		chk(rd_v & 32'h0000_00F8, 32'h0000_00F8);
		step(8'hA4, ST_START);
		jam <= 1'b1;
		wr(OFS_DATA, 8'hA0);
		step(8'h84, ST_LOST);
		jam <= 1'b0;
		step(8'hA4, ST_START);
		wr(OFS_DATA, 8'hA0);
		step(8'h84, ST_SLAW_ACK);
		wr(OFS_CTRL, 8'h94);
		rd(OFS_STAT);
		while ((rd_v[7:0] & 8'hF8) !== ST_NONE) rd(OFS_STAT);
		rd(OFS_CTRL);
		chk(rd_v & 32'h0000_0090, 32'h0000_0000);
		final_report;
	end
endmodule
`default_nettype wire
